// ===== pllho_cfg.svh
/*
 * register offsets, field positions, reset values and encodings
 * for the pll holdover controller; included by the top module and the bench, not by pllho_pkg.sv
 */
`ifndef PLLHO_CFG_SVH
`define PLLHO_CFG_SVH

// register indices (byte address is index times four)
`define PLLHO_IDX_LOCK_DETECT_CONFIG 12'h018
`define PLLHO_IDX_LOCK_PIN_MONITOR 12'h01a
`define PLLHO_IDX_REFERENCE_SELECT 12'h01c
`define PLLHO_IDX_HOLDOVER_CTRL 12'h01d
`define PLLHO_IDX_CHANNEL0_DIVIDER 12'h191
`define PLLHO_IDX_CHANNEL1_DIVIDER 12'h194
`define PLLHO_IDX_CHANNEL2_DIVIDER 12'h197
`define PLLHO_IDX_CHANNEL3_DIVIDER 12'h19a
`define PLLHO_IDX_STATUS 12'h1f0

// field positions
`define PLLHO_HO_ENABLE_BIT 0
`define PLLHO_HO_EXTERNAL_BIT 1
`define PLLHO_HO_PIN_CMP_BIT 3
`define PLLHO_LD_DISABLE_BIT 3
`define PLLHO_LD_WINDOW_BIT 4
`define PLLHO_LD_COUNT_LSB 5
`define PLLHO_PIN_MODE_MSB 5
`define PLLHO_MON_EXT_BIT 6
`define PLLHO_REF_BUF_LSB 1
`define PLLHO_REF_PREFER_BIT 3
`define PLLHO_REF_AUTO_BIT 4
`define PLLHO_CH_IGNORE_ALIGN_BIT 6

// encodings
`define PLLHO_PIN_MODE_CURRENT_SOURCE_LOCK_DETECT 6'h04
`define PLLHO_PIN_MODE_DLD 6'h01
`define PLLHO_PIN_MODE_ALD_N 6'h02
`define PLLHO_PIN_MODE_ALD_P 6'h03

// reset values
`define PLLHO_RST_LOCK_DETECT 8'h00
`define PLLHO_RST_LOCK_PIN 8'h00
`define PLLHO_RST_REF_SELECT 8'h00
`define PLLHO_RST_HOLDOVER 8'h00
`define PLLHO_RST_CHANNEL 8'h00

`endif

// ===== pllho_pkg.sv
/*
 * types for the pll holdover controller.
 * assumes pllho_cfg.svh sits in the same folder.
 */
`default_nettype none

package pllho_pkg;
	// holdover state, one-hot
	typedef enum logic [2:0] {
		PLLHO_ST_RUN = 3'h1,
		PLLHO_ST_HOLD = 3'h2,
		PLLHO_ST_REARM = 3'h4
	} pllho_state_type;

	// source of the clock input
	typedef enum logic [1:0] {
		PLLHO_CLK_VCO = 2'h0,
		PLLHO_CLK_DIST_ONLY = 2'h1,
		PLLHO_CLK_EXT_VCO = 2'h2,
		PLLHO_CLK_ZERO_DELAY = 2'h3
	} pllho_clk_src_type;
endpackage : pllho_pkg

`default_nettype wire

// ===== pllho_top.sv
/*
 * pll holdover controller: axi4-lite register file, digital lock
 * detect, holdover state machine, counter realignment and frequency
 * monitor status.
 * assumes aclk is the phase detector clock domain and that
 * pfd_ref_edge / pfd_fb_edge / phase error inputs come from logic
 * on aclk; pins (alignment, lock indicator, monitors) are asynchronous.
 */
`default_nettype none
`include "pllho_cfg.svh"

// Behaviour
// - holdover enable bit clear blocks both manual and automatic holdover
// - manual mode: falling edge of alignment pin tristates charge pump at once
// - release only at next reference phase detector edge after pin is high
// - no reference edge keeps manual holdover in place
// - release resets the b counter at the same edge, prescaler untouched
// - automatic mode tristates charge pump on lock loss without software
// - automatic entry follows the sensed lock indicator pin level
// - comparator disabled makes the lock indicator read permanently high
// - automatic holdover persists while no reference edge arrives
// - after exit, rearm only once the lock indicator returns high
// - only the selected reference counts; switchover loss ends next edge
// - lock counter field picks consecutive in-window cycles; 00b gives five
// - digital lock detect runs only when its disable bit is zero
// - pin control 000100b selects current-source lock detect on the pin
// - external holdover bit zero picks automatic mode over pin mode
// - reference select: auto switch, prefer second, buffer enables
// - lock window bit zero selects high range window
// - three monitors flag low frequency on both references and oscillator
// - one bit picks normal or extended reference monitor threshold
// - clock input is internal vco, distribution-only, external vco feedback or zero delay
// - lock after programmed consecutive cycles, drop on one wide error
module pllho_top
	import pllho_pkg::*;
#(
	parameter int ADDR_WIDTH = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// asynchronous pins
	input wire logic align_pin_n,
	input wire logic lock_indicator_pin,
	input wire logic [2:0] monitor_low_freq,
	// phase detector events on aclk
	input wire logic pfd_ref_edge_first,
	input wire logic pfd_ref_edge_second,
	input wire logic pfd_fb_edge,
	input wire logic phase_in_lock_window,
	input wire logic phase_over_unlock_window,
	input wire logic ref_selected_second,
	// loop and status outputs
	output logic charge_pump_tristate,
	output logic b_counter_reset,
	output logic digital_lock_detect,
	output logic [5:0] lock_pin_mode,
	output logic lock_window_high_range,
	output logic monitor_extended_threshold,
	output logic [2:0] monitor_flags,
	output logic ref_auto_switch,
	output logic ref_prefer_second,
	output logic [1:0] ref_buffer_enable,
	output logic [1:0] clk_input_source,
	output logic [3:0] channel_ignore_align
);

	//--------------------------------------------------------------
	// register file
	//--------------------------------------------------------------
	logic [7:0] pll_lock_detect_config;
	logic [7:0] lock_pin_and_monitor_ctrl;
	logic [7:0] reference_select_ctrl;
	logic [7:0] holdover_ctrl;
	logic [7:0] channel_divider_ctrl [4];
	logic [1:0] clock_source_ctrl;
	logic aw_held;
	logic w_held;
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [2:0] hold_cause_sticky;

	// channel index decode, -1 style miss reported as 3'h4
	function automatic logic [2:0] pllho_channel_index(input logic [ADDR_WIDTH-1:0] addr);
		case (addr)
			`PLLHO_IDX_CHANNEL0_DIVIDER * 4: pllho_channel_index = 3'h0;
			`PLLHO_IDX_CHANNEL1_DIVIDER * 4: pllho_channel_index = 3'h1;
			`PLLHO_IDX_CHANNEL2_DIVIDER * 4: pllho_channel_index = 3'h2;
			`PLLHO_IDX_CHANNEL3_DIVIDER * 4: pllho_channel_index = 3'h3;
			default: pllho_channel_index = 3'h4;
		endcase
	endfunction : pllho_channel_index

	// true for any mapped register address
	function automatic logic pllho_mapped(input logic [ADDR_WIDTH-1:0] addr);
		case (addr)
			`PLLHO_IDX_LOCK_DETECT_CONFIG * 4, `PLLHO_IDX_LOCK_PIN_MONITOR * 4,
			`PLLHO_IDX_REFERENCE_SELECT * 4, `PLLHO_IDX_HOLDOVER_CTRL * 4,
			`PLLHO_IDX_STATUS * 4: pllho_mapped = 1'b1;
			default: pllho_mapped = pllho_channel_index(addr) != 3'h4;
		endcase
	endfunction : pllho_mapped

	// decoded channel slots; 3'h4 means no channel register
	logic [2:0] wr_ch;
	logic [2:0] rd_ch;
	assign wr_ch = pllho_channel_index(aw_addr);
	assign rd_ch = pllho_channel_index(s_axi_araddr);

	logic do_write;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// address and data may arrive in either order; each is held until both are here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// ready only while the matching holding slot is empty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= pllho_mapped(aw_addr) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register writes gated by byte lane 0; the status clock source takes data bits 9:8
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_lock_detect_config <= `PLLHO_RST_LOCK_DETECT;
			lock_pin_and_monitor_ctrl <= `PLLHO_RST_LOCK_PIN;
			reference_select_ctrl <= `PLLHO_RST_REF_SELECT;
			holdover_ctrl <= `PLLHO_RST_HOLDOVER;
			clock_source_ctrl <= 2'h0;
			for (int i = 0; i < 4; i++) begin
				channel_divider_ctrl[i] <= `PLLHO_RST_CHANNEL;
			end
		end else if (do_write && w_strb[0]) begin
			case (aw_addr)
				`PLLHO_IDX_LOCK_DETECT_CONFIG * 4: pll_lock_detect_config <= w_data[7:0];
				`PLLHO_IDX_LOCK_PIN_MONITOR * 4: lock_pin_and_monitor_ctrl <= w_data[7:0];
				`PLLHO_IDX_REFERENCE_SELECT * 4: reference_select_ctrl <= w_data[7:0];
				`PLLHO_IDX_HOLDOVER_CTRL * 4: holdover_ctrl <= w_data[7:0];
				`PLLHO_IDX_STATUS * 4: clock_source_ctrl <= w_data[9:8];
				default: begin
					if (wr_ch != 3'h4) begin
						channel_divider_ctrl[wr_ch[1:0]] <= w_data[7:0];
					end
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------------------
	logic [1:0] align_sync;
	logic [1:0] lock_pin_sync;
	logic [2:0] mon_sync0;
	logic [2:0] mon_sync1;
	logic align_prev;

	// two stages each; only the second stage is looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			align_sync <= 2'h3;
			lock_pin_sync <= 2'h0;
			mon_sync0 <= 3'h0;
			mon_sync1 <= 3'h0;
			align_prev <= 1'b1;
		end else begin
			align_sync <= {align_sync[0], align_pin_n};
			lock_pin_sync <= {lock_pin_sync[0], lock_indicator_pin};
			mon_sync0 <= monitor_low_freq;
			mon_sync1 <= mon_sync0;
			align_prev <= align_sync[1];
		end
	end

	logic align_fall;
	logic lock_sensed;
	logic ref_edge;
	assign align_fall = align_prev && !align_sync[1];
	// comparator off reads as permanently high
	assign lock_sensed = holdover_ctrl[`PLLHO_HO_PIN_CMP_BIT] ? lock_pin_sync[1] : 1'b1;
	// only the currently selected reference is watched
	assign ref_edge = ref_selected_second ? pfd_ref_edge_second : pfd_ref_edge_first;

	//--------------------------------------------------------------
	// digital lock detect
	//--------------------------------------------------------------
	logic [4:0] lock_count;
	logic [4:0] lock_target;

	// counter field 00b selects five; the other codes are parameters of choice
	always_comb begin
		case (pll_lock_detect_config[`PLLHO_LD_COUNT_LSB +: 2])
			2'h0: lock_target = 5'd5;
			2'h1: lock_target = 5'd16;
			2'h2: lock_target = 5'd16;
			default: lock_target = 5'd31;
		endcase
	end

	// hysteresis: slow in, fast out, so the indicator does not chatter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_count <= 5'h0;
			digital_lock_detect <= 1'b0;
		end else if (pll_lock_detect_config[`PLLHO_LD_DISABLE_BIT]) begin
			lock_count <= 5'h0;
			digital_lock_detect <= 1'b0;
		end else if (pfd_fb_edge) begin
			if (phase_over_unlock_window) begin
				lock_count <= 5'h0;
				digital_lock_detect <= 1'b0;
			end else if (phase_in_lock_window) begin
				if (lock_count + 5'h1 >= lock_target) begin
					digital_lock_detect <= 1'b1;
				end
				if (lock_count != 5'h1f) begin
					lock_count <= lock_count + 5'h1;
				end
			end else begin
				lock_count <= 5'h0;
			end
		end
	end

	//--------------------------------------------------------------
	// holdover state machine
	//--------------------------------------------------------------
	pllho_state_type state;
	pllho_state_type next_state;
	logic ho_enable;
	logic ho_external;
	logic enter_manual;
	logic enter_auto;
	logic release_now;
	assign ho_enable = holdover_ctrl[`PLLHO_HO_ENABLE_BIT];
	assign ho_external = holdover_ctrl[`PLLHO_HO_EXTERNAL_BIT];
	assign enter_manual = ho_enable && ho_external && align_fall;
	assign enter_auto = ho_enable && !ho_external && !lock_sensed;
	// release waits for the pin (manual mode) and the next reference edge
	assign release_now = ref_edge && (!ho_external || align_sync[1]);

	always_comb begin
		next_state = state;
		case (state)
			PLLHO_ST_RUN: begin
				if (enter_manual || enter_auto) begin
					next_state = PLLHO_ST_HOLD;
				end
			end
			PLLHO_ST_HOLD: begin
				if (!ho_enable) begin
					next_state = PLLHO_ST_RUN;
				end else if (release_now) begin
					next_state = ho_external ? PLLHO_ST_RUN : PLLHO_ST_REARM;
				end
			end
			PLLHO_ST_REARM: begin
				// automatic entry blocked until the indicator is high again
				if (lock_sensed || !ho_enable || ho_external) begin
					next_state = PLLHO_ST_RUN;
				end else if (enter_manual) begin
					next_state = PLLHO_ST_HOLD;
				end
			end
			default: next_state = PLLHO_ST_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= PLLHO_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// tristate goes with the state; the b counter reset marks the release edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			charge_pump_tristate <= 1'b0;
			b_counter_reset <= 1'b0;
		end else begin
			charge_pump_tristate <= next_state == PLLHO_ST_HOLD;
			b_counter_reset <= state == PLLHO_ST_HOLD && next_state != PLLHO_ST_HOLD && release_now;
		end
	end

	// sticky cause bits: bit0 manual, bit1 automatic, bit2 released; set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_cause_sticky <= 3'h0;
		end else begin
			hold_cause_sticky <= (hold_cause_sticky
				& ~((do_write && w_strb[1] && aw_addr == `PLLHO_IDX_STATUS * 4) ? w_data[14:12] : 3'h0))
				| {state == PLLHO_ST_HOLD && release_now,
					state == PLLHO_ST_RUN && enter_auto,
					state != PLLHO_ST_HOLD && enter_manual};
		end
	end

	//--------------------------------------------------------------
	// configuration outputs and monitors
	//--------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_pin_mode <= 6'h0;
			lock_window_high_range <= 1'b1;
			monitor_extended_threshold <= 1'b0;
			monitor_flags <= 3'h0;
			ref_auto_switch <= 1'b0;
			ref_prefer_second <= 1'b0;
			ref_buffer_enable <= 2'h0;
			clk_input_source <= 2'h0;
			channel_ignore_align <= 4'h0;
		end else begin
			lock_pin_mode <= lock_pin_and_monitor_ctrl[`PLLHO_PIN_MODE_MSB:0];
			lock_window_high_range <= !pll_lock_detect_config[`PLLHO_LD_WINDOW_BIT];
			monitor_extended_threshold <= lock_pin_and_monitor_ctrl[`PLLHO_MON_EXT_BIT];
			monitor_flags <= mon_sync1;
			ref_auto_switch <= reference_select_ctrl[`PLLHO_REF_AUTO_BIT];
			ref_prefer_second <= reference_select_ctrl[`PLLHO_REF_PREFER_BIT];
			ref_buffer_enable <= reference_select_ctrl[`PLLHO_REF_BUF_LSB +: 2];
			clk_input_source <= clock_source_ctrl;
			for (int i = 0; i < 4; i++) begin
				channel_ignore_align[i] <= channel_divider_ctrl[i][`PLLHO_CH_IGNORE_ALIGN_BIT];
			end
		end
	end

	//--------------------------------------------------------------
	// read channel
	//--------------------------------------------------------------
	logic [7:0] read_byte;
	logic current_source_lock_detect_selected;
	assign current_source_lock_detect_selected = lock_pin_and_monitor_ctrl[`PLLHO_PIN_MODE_MSB:0] == `PLLHO_PIN_MODE_CURRENT_SOURCE_LOCK_DETECT;

	always_comb begin
		case (s_axi_araddr)
			`PLLHO_IDX_LOCK_DETECT_CONFIG * 4: read_byte = pll_lock_detect_config;
			`PLLHO_IDX_LOCK_PIN_MONITOR * 4: read_byte = lock_pin_and_monitor_ctrl;
			`PLLHO_IDX_REFERENCE_SELECT * 4: read_byte = reference_select_ctrl;
			`PLLHO_IDX_HOLDOVER_CTRL * 4: read_byte = holdover_ctrl;
			default: read_byte = rd_ch != 3'h4 ? channel_divider_ctrl[rd_ch[1:0]] : 8'h0;
		endcase
	end

	// one read at a time; answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pllho_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			if (s_axi_araddr == `PLLHO_IDX_STATUS * 4) begin
				s_axi_rdata <= {17'h0, hold_cause_sticky, 2'h0, clock_source_ctrl, mon_sync1,
					current_source_lock_detect_selected, lock_sensed, digital_lock_detect, state == PLLHO_ST_REARM,
					charge_pump_tristate};
			end else begin
				s_axi_rdata <= {24'h0, read_byte};
			end
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule : pllho_top

`default_nettype wire

// ===== pllho_checker.sv
/*
 * holdover and lock detect checks on pllho_top.
 * assumes aclk and synchronous active-low aresetn.
 */
`default_nettype none

module pllho_checker #(
	parameter int ADDR_WIDTH = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register writes
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// pins and phase detector events
	input wire logic align_pin_n,
	input wire logic pfd_ref_edge_first,
	input wire logic pfd_ref_edge_second,
	input wire logic pfd_fb_edge,
	input wire logic phase_in_lock_window,
	input wire logic phase_over_unlock_window,
	input wire logic ref_selected_second,
	// loop outputs
	input wire logic charge_pump_tristate,
	input wire logic b_counter_reset,
	input wire logic digital_lock_detect
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	localparam logic [ADDR_WIDTH-1:0] HO_A = ADDR_WIDTH'(12'h074);
	logic [ADDR_WIDTH-1:0] wa;
	logic [7:0] wd;
	logic ws, bv_q, ho_en_m, ext_m;
	logic [2:0] run;
	wire logic sel_edge = ref_selected_second ? pfd_ref_edge_second : pfd_ref_edge_first;

	// mirror of the holdover bits, taken when the write answer first shows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws <= 1'b0;
			bv_q <= 1'b0;
			ho_en_m <= 1'b0;
			ext_m <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) {ws, wd} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
			bv_q <= s_axi_bvalid;
			if (s_axi_bvalid && !bv_q && ws && wa == HO_A) {ext_m, ho_en_m} <= wd[1:0];
		end
	end

	// run of consecutive in-window compares, saturating so it cannot wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run <= 3'h0;
		end else if (pfd_fb_edge) begin
			run <= !phase_in_lock_window ? 3'h0 : (run == 3'h7 ? run : run + 3'h1);
		end
	end

	holdover_off_a: assert property (!ho_en_m [*3] |-> !charge_pump_tristate)
		else $error("charge pump held while holdover disabled");
	entry_enabled_a: assert property ($rose(charge_pump_tristate) |-> ho_en_m)
		else $error("holdover entered without enable");
	manual_entry_a: assert property ($fell(align_pin_n) && ho_en_m && ext_m |-> ##[1:5] charge_pump_tristate)
		else $error("pin fall did not start holdover");
	release_edge_a: assert property (b_counter_reset |->
		!charge_pump_tristate && $past(charge_pump_tristate) && $past(sel_edge))
		else $error("release without selected reference edge");
	manual_release_a: assert property (b_counter_reset && ext_m |-> $past(align_pin_n, 2))
		else $error("manual release while pin low");
	hold_stays_a: assert property (charge_pump_tristate && ho_en_m && !sel_edge |=>
		charge_pump_tristate || !ho_en_m || s_axi_bvalid)
		else $error("holdover left with no reference edge");
	lock_count_a: assert property ($rose(digital_lock_detect) |-> run >= 3'h5)
		else $error("lock declared too early");
	lock_drop_a: assert property (pfd_fb_edge && phase_over_unlock_window |=> !digital_lock_detect)
		else $error("lock kept after unlock error");
endmodule : pllho_checker

bind pllho_top pllho_checker #(.ADDR_WIDTH(ADDR_WIDTH)) checker_u (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .align_pin_n, .pfd_ref_edge_first,
	.pfd_ref_edge_second, .pfd_fb_edge, .phase_in_lock_window, .phase_over_unlock_window,
	.ref_selected_second, .charge_pump_tristate, .b_counter_reset, .digital_lock_detect
);

`default_nettype wire

// ===== pllho_ref_model.sv
/*
 * references and feedback loop at the phase detector.
 * assumes aclk is that clock; events every PER cycles.
 */
`default_nettype none

module pllho_ref_model #(
	parameter int PER = 8
) (
	// clock and controls
	input wire logic aclk,
	input wire logic [1:0] ref_on,
	input wire logic lock_good,
	// phase detector events
	output var logic pfd_ref_edge_first = 1'b0,
	output var logic pfd_ref_edge_second = 1'b0,
	output var logic pfd_fb_edge = 1'b0,
	output var logic phase_in_lock_window = 1'b0,
	output var logic phase_over_unlock_window = 1'b1
);
	int cnt = 0;

	// window levels toggle between compares so stale values never look valid
	always @(posedge aclk) begin
		cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		pfd_ref_edge_first <= ref_on[0] && cnt == 0;
		pfd_ref_edge_second <= ref_on[1] && cnt == 0;
		pfd_fb_edge <= ref_on != 2'h0 && cnt == 1;
		phase_in_lock_window <= (cnt == 1) ? lock_good : !phase_in_lock_window;
		phase_over_unlock_window <= (cnt == 1) ? !lock_good : !phase_over_unlock_window;
	end
endmodule : pllho_ref_model

`default_nettype wire

// ===== pllho_top_test.sv
/*
 * bench for pllho_top: registers, lock detect, holdover.
 * assumes pllho_ref_model drives the phase detector.
 */
`default_nettype none
`include "pllho_cfg.svh"

module pllho_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 8;
	localparam logic [11:0] A_ALL [8] = '{`PLLHO_IDX_LOCK_DETECT_CONFIG << 2, `PLLHO_IDX_LOCK_PIN_MONITOR << 2,
		`PLLHO_IDX_REFERENCE_SELECT << 2, `PLLHO_IDX_HOLDOVER_CTRL << 2, `PLLHO_IDX_CHANNEL0_DIVIDER << 2,
		`PLLHO_IDX_CHANNEL1_DIVIDER << 2, `PLLHO_IDX_CHANNEL2_DIVIDER << 2, `PLLHO_IDX_CHANNEL3_DIVIDER << 2};
	localparam logic [11:0] A_ST = `PLLHO_IDX_STATUS << 2;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, align_pin_n = 1'b1, lock_indicator_pin = 1'b1, ref_selected_second = 1'b0;
	logic [2:0] monitor_low_freq = 3'h0, monitor_flags;
	logic [1:0] ref_on = 2'h0, s_axi_bresp, s_axi_rresp, r, ref_buffer_enable, clk_input_source;
	logic lock_good = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pfd_ref_edge_first, pfd_ref_edge_second, pfd_fb_edge, phase_in_lock_window, phase_over_unlock_window;
	logic charge_pump_tristate, b_counter_reset, digital_lock_detect, lock_window_high_range;
	logic monitor_extended_threshold, ref_auto_switch, ref_prefer_second;
	logic [5:0] lock_pin_mode;
	logic [3:0] channel_ignore_align;
	int n_fail = 0, n_compared = 0, cycles = 0;

	pllho_top #(.ADDR_WIDTH(12)) dut_u (.*);
	pllho_ref_model #(.PER(PER)) partner_u (.*);

	// ----------------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------------
	always #5 aclk = ~aclk;

	// ceiling sits far above the few hundred cycles the tests need
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic wait_rel;
		while (b_counter_reset !== 1'b1) @(posedge aclk);
		chk({30'h0, charge_pump_tristate, b_counter_reset}, 32'h1);
	endtask : wait_rel

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		for (int i = 0; i < 8; i++) begin
			rd(A_ALL[i], d, r);
			chk({d[31:2], r}, 32'h0);
		end
		rd(12'h004, d, r);
		chk({d[31:2], r}, 32'h2);
		wr(12'h004, 32'h1);
		chk(r, 2);
		chk(lock_window_high_range, 1);
		for (int i = 4; i < 8; i++) wr(A_ALL[i], 32'h40);
		chk(r, 0);
		rd(A_ALL[7], d, r);
		chk(d, 32'h40);
		chk(channel_ignore_align, 15);
		$display("test regs done");
	endtask : t_regs

	task automatic t_fields;
		wr(A_ALL[1], 32'h44);
		chk({monitor_extended_threshold, lock_pin_mode}, 32'h44);
		wr(A_ALL[2], 32'h16);
		chk({ref_auto_switch, ref_prefer_second, ref_buffer_enable}, 32'hb);
		wr(A_ALL[0], 32'h10);
		chk(lock_window_high_range, 0);
		wr(A_ALL[0], 32'h00);
		chk(lock_window_high_range, 1);
		for (int k = 0; k < 4; k++) begin
			wr(A_ST, 32'(k) << 8);
			chk(clk_input_source, k);
		end
		monitor_low_freq <= 3'h5;
		tick(5);
		rd(A_ST, d, r);
		chk({monitor_flags, d[7:5]}, 32'h2d);
		$display("test fields done");
	endtask : t_fields

	// five compares in window give lock; one wide error drops it
	task automatic t_lock;
		ref_on <= 2'h3;
		lock_good <= 1'b1;
		tick(3 * PER);
		chk(digital_lock_detect, 0);
		tick(4 * PER);
		chk(digital_lock_detect, 1);
		lock_good <= 1'b0;
		tick(PER + 2);
		chk(digital_lock_detect, 0);
		lock_good <= 1'b1;
		wr(A_ALL[0], 32'h08);
		tick(8 * PER);
		chk(digital_lock_detect, 0);
		wr(A_ALL[0], 32'h00);
		$display("test lock done");
	endtask : t_lock

	task automatic t_manual;
		ref_on <= 2'h0;
		wr(A_ALL[3], 32'h02);
		align_pin_n <= 1'b0;
		tick(8);
		chk(charge_pump_tristate, 0);
		align_pin_n <= 1'b1;
		wr(A_ALL[3], 32'h03);
		align_pin_n <= 1'b0;
		tick(6);
		chk(charge_pump_tristate, 1);
		align_pin_n <= 1'b1;
		tick(4 * PER);
		chk(charge_pump_tristate, 1);
		ref_on <= 2'h1;
		wait_rel();
		tick(1);
		chk(b_counter_reset, 0);
		// sticky causes: manual entry and release seen, then cleared
		rd(A_ST, d, r);
		chk(d[14:12], 3'h5);
		wr(A_ST, 32'h7000);
		rd(A_ST, d, r);
		chk(d[14:12], 3'h0);
		align_pin_n <= 1'b0;
		tick(4 * PER);
		chk(charge_pump_tristate, 1);
		align_pin_n <= 1'b1;
		wait_rel();
		$display("test manual done");
	endtask : t_manual

	task automatic t_auto;
		ref_on <= 2'h0;
		wr(A_ALL[3], 32'h09);
		lock_indicator_pin <= 1'b0;
		tick(6);
		chk(charge_pump_tristate, 1);
		tick(4 * PER);
		chk(charge_pump_tristate, 1);
		ref_selected_second <= 1'b1;
		ref_on <= 2'h1;
		tick(3 * PER);
		chk(charge_pump_tristate, 1);
		ref_on <= 2'h2;
		wait_rel();
		ref_on <= 2'h0;
		tick(4 * PER);
		chk(charge_pump_tristate, 0);
		lock_indicator_pin <= 1'b1;
		tick(6);
		lock_indicator_pin <= 1'b0;
		tick(6);
		chk(charge_pump_tristate, 1);
		wr(A_ALL[3], 32'h00);
		chk(charge_pump_tristate, 0);
		wr(A_ALL[3], 32'h01);
		align_pin_n <= 1'b0;
		tick(8);
		chk(charge_pump_tristate, 0);
		align_pin_n <= 1'b1;
		$display("test auto done");
	endtask : t_auto

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_regs();
		t_fields();
		t_lock();
		t_manual();
		t_auto();
		final_report();
	end
endmodule : pllho_top_test

`default_nettype wire
